// [rtl/dspb_bank.v]
// drive status parameter bank, read by parameter address
`timescale 1ns/100ps
`default_nettype none
`include "dspb_defs.vh"

module dspb_bank #(
  parameter [31:0] SAMPLE_CYC = `DSPB_SAMPLE_CYC
) (
  input  wire        ref_clk_i,
  input  wire        rst_i,
  // parameter access port from the fieldbus engine
  input  wire        req_i,
  input  wire        wr_i,
  input  wire [15:0] addr_i,
  output reg  [31:0] rdata_o,
  output reg         ack_o,
  output reg         err_o,
  // drive status sources, same clock domain
  input  wire [31:0] ref_speed_i,
  input  wire [31:0] act_speed_i,
  input  wire        warn_i,
  input  wire [3:0]  err_class_i,
  input  wire [7:0]  chan_id_i,
  input  wire        chan_excl_i,
  input  wire [15:0] opmode_i,
  // live copies for the drive's own use
  output wire [15:0] action_word_o,
  output wire [31:0] ref_acc_o
);

  reg  [15:0] access_q;
  reg  [15:0] access_d;
  reg  [15:0] opmode_q;
  reg  [15:0] opmode_d;
  reg  [15:0] action_q;
  reg  [15:0] action_d;
  wire [31:0] acc_w;
  wire        acc_tick;

  reg         ch_ok;
  reg         mode_ok;
  reg         still;
  reg         cw;
  reg         ccw;
  reg         idle;
  reg         acc_nz;
  reg         same_sign;
  reg  [31:0] abs_act;

  reg         hit;
  reg  [31:0] rsel;

  assign action_word_o = action_q;
  assign ref_acc_o     = acc_w;

  dspb_acc_est #(
    .SAMPLE_CYC (SAMPLE_CYC)
  ) u_acc (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .ref_speed_i (ref_speed_i),
    .acc_o       (acc_w),
    .tick_o      (acc_tick)
  );

  // ---- access channel indication ----
  always @* begin
    ch_ok = (chan_id_i != `DSPB_CH_RSVD0) &&
            (chan_id_i != `DSPB_CH_RSVD8) &&
            (chan_id_i <= `DSPB_CH_MAX);
    access_d = access_q;
    if (ch_ok) begin
      access_d[15:8] = chan_id_i;
      access_d[7:0] = chan_excl_i ? `DSPB_USE_EXCL
                                  : `DSPB_USE_SHARED;
    end
  end

  // ---- active operating mode ----
  always @* begin
    mode_ok = ($signed(opmode_i) >= $signed(`DSPB_MODE_MIN)) &&
              ($signed(opmode_i) <= $signed(`DSPB_MODE_MAX));
    // out-of-range codes keep the last valid mode rather than
    // exposing a transient value to the master
    opmode_d = mode_ok ? opmode_i : opmode_q;
  end

  // ---- motion classification ----
  always @* begin
    abs_act = act_speed_i[31] ? (32'h00000000 - act_speed_i)
                              : act_speed_i;
    still = (abs_act < `DSPB_STILL_RPM);
    cw  = !still && !act_speed_i[31];
    ccw = !still &&  act_speed_i[31];
    idle = (ref_speed_i == 32'h00000000);
    acc_nz    = (acc_w != 32'h00000000);
    same_sign = (acc_w[31] == ref_speed_i[31]);
  end

  // ---- action word ----
  always @* begin
    action_d = 16'h0000;
    action_d[`DSPB_BIT_WARN] = warn_i;
    action_d[`DSPB_BIT_ERR1 +: 4] = err_class_i;
    action_d[`DSPB_BIT_STILL] = still;
    action_d[`DSPB_BIT_CW]    = cw;
    action_d[`DSPB_BIT_CCW]   = ccw;
    action_d[`DSPB_BIT_IDLE]  = idle;
    action_d[`DSPB_BIT_DECEL] = !idle && acc_nz && !same_sign;
    action_d[`DSPB_BIT_ACCEL] = !idle && acc_nz &&  same_sign;
    action_d[`DSPB_BIT_CONST] = !idle && !acc_nz;
    action_d[5]  = 1'b0;
    action_d[9]  = 1'b0;
    action_d[10] = 1'b0;
    action_d[15] = 1'b0;
  end

  // the action word follows its sources every cycle, access and mode only on valid codes; the
  // acceleration itself only moves on the sample tick
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      access_q <= `DSPB_RST_ACCESS;
      opmode_q <= `DSPB_RST_OPMODE;
      action_q <= `DSPB_RST_ACTION;
    end else begin
      access_q <= access_d;
      opmode_q <= opmode_d;
      action_q <= action_d;
    end
  end

  // ---- parameter address decode ----
  always @* begin
    hit  = 1'b1;
    rsel = 32'h00000000;
    case (addr_i)
      `DSPB_ADR_ACCESS: begin
        rsel = {16'h0000, access_q};
      end
      `DSPB_ADR_OPMODE: begin
        rsel = {{16{opmode_q[15]}}, opmode_q};
      end
      `DSPB_ADR_ACTION: begin
        rsel = {16'h0000, action_q};
      end
      `DSPB_ADR_REFACC: begin
        rsel = acc_w;
      end
      default: begin
        hit  = 1'b0;
        rsel = 32'h00000000;
      end
    endcase
  end

  // one request answered on the next edge; a write or an
  // unmapped address gets err_o and rdata_o of zero, and changes no parameter
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h00000000;
      ack_o   <= 1'b0;
      err_o   <= 1'b0;
    end else begin
      ack_o <= req_i;
      err_o <= 1'b0;
      if (req_i) begin
        if (wr_i || !hit) begin
          err_o   <= 1'b1;
          rdata_o <= 32'h00000000;
        end else begin
          rdata_o <= rsel;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [rtl/dspb_defs.vh]
// constants for the drive status parameter bank
`ifndef DSPB_DEFS_VH
`define DSPB_DEFS_VH

// parameter addresses as seen by the fieldbus master
`define DSPB_ADR_ACCESS    16'h0118
`define DSPB_ADR_OPMODE    16'h1B08
`define DSPB_ADR_ACTION    16'h1C08
`define DSPB_ADR_REFACC    16'h1F12

// reset values
`define DSPB_RST_ACCESS    16'h0000
`define DSPB_RST_OPMODE    16'h0000
`define DSPB_RST_ACTION    16'h0000
`define DSPB_RST_REFACC    32'h00000000

// action word bit positions
`define DSPB_BIT_WARN      0
`define DSPB_BIT_ERR1      1
`define DSPB_BIT_STILL     6
`define DSPB_BIT_CW        7
`define DSPB_BIT_CCW       8
`define DSPB_BIT_IDLE      11
`define DSPB_BIT_DECEL     12
`define DSPB_BIT_ACCEL     13
`define DSPB_BIT_CONST     14

// access channel codes carried in the high byte, use codes in the low byte
`define DSPB_CH_RSVD0      8'h00
`define DSPB_CH_MAX        8'h09
`define DSPB_CH_RSVD8      8'h08
`define DSPB_USE_SHARED    8'h00
`define DSPB_USE_EXCL      8'h01

// standstill threshold in revolutions per minute
`define DSPB_STILL_RPM     32'h00000009

// operating mode code range
`define DSPB_MODE_MIN      16'hFFFA
`define DSPB_MODE_MAX      16'h0006

// acceleration sampling: period in us, clock in MHz
`define DSPB_SAMPLE_US     1000
`define DSPB_CLK_MHZ       50
`define DSPB_SAMPLE_CYC    (`DSPB_SAMPLE_US * `DSPB_CLK_MHZ)
`define DSPB_SAMPLES_PER_S 32'h000003E8

`endif

// [rtl/dspb_acc_est.v]
// reference acceleration estimator from sampled reference speed
`timescale 1ns/100ps
`default_nettype none
`include "dspb_defs.vh"

module dspb_acc_est #(
  parameter [31:0] SAMPLE_CYC = `DSPB_SAMPLE_CYC
) (
  input  wire        ref_clk_i,
  input  wire        rst_i,
  input  wire [31:0] ref_speed_i,
  output reg  [31:0] acc_o,
  output reg         tick_o
);

  localparam [31:0] CNT_LAST = SAMPLE_CYC - 32'h00000001;

  reg  [31:0] cnt_q;
  reg  [31:0] prev_q;
  wire [31:0] diff;

  // speed change over one period, scaled to per-second
  assign diff = ref_speed_i - prev_q;

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= 32'h00000000;
      prev_q <= 32'h00000000;
      acc_o  <= `DSPB_RST_REFACC;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (cnt_q >= CNT_LAST) begin
        cnt_q  <= 32'h00000000;
        prev_q <= ref_speed_i;
        acc_o  <= diff * `DSPB_SAMPLES_PER_S;
        tick_o <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 32'h00000001;
      end
    end
  end

endmodule
`default_nettype wire

// [verification/dspb_props.sv]
// assertion checker for the parameter bank
`timescale 1ns/100ps
`default_nettype none
module dspb_props #(
  parameter [31:0] SAMPLE_CYC = 32'h8
) (
  input wire        ref_clk_i,
  input wire        rst_i,
  input wire        req_i,
  input wire        wr_i,
  input wire [31:0] rdata_o,
  input wire        ack_o,
  input wire        err_o,
  input wire [31:0] ref_speed_i,
  input wire        warn_i,
  input wire [3:0]  err_class_i,
  input wire [15:0] action_word_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows: assert property (req_i |=> ack_o) else $error("no ack");
  a_no_stray: assert property (!req_i |=> !ack_o) else $error("stray ack");
  a_write_refused: assert property (req_i && wr_i |=> err_o) else $error("write");
  a_err_zero: assert property (err_o |-> rdata_o == 32'h0) else $error("data");
  a_idle_flag: assert property (ref_speed_i == '0 |=> action_word_o[11])
    else $error("idle");
  a_one_phase: assert property (1'b1 |=> $onehot(action_word_o[14:11]))
    else $error("phase");
  a_spare_zero: assert property ((action_word_o & 16'h8620) == 16'h0)
    else $error("spare");
  a_fault_flags: assert property (1'b1 |=> action_word_o[4:0] ==
    {$past(err_class_i), $past(warn_i)}) else $error("faults");
  cover property (req_i && wr_i);
  cover property (action_word_o[13]);
  cover property (action_word_o[12]);
endmodule
bind dspb_bank dspb_props #(.SAMPLE_CYC(SAMPLE_CYC)) i_props (.*);
`default_nettype wire

// [verification/dspb_master.sv]
// fieldbus master model
`timescale 1ns/100ps
`default_nettype none
module dspb_master (
  input  wire         ref_clk_i,
  output logic        req_o = 1'b0,
  output logic        wr_o = 1'b0,
  output logic [15:0] addr_o = 16'h0
);
  task automatic put(input logic [15:0] a, input logic w);
    @(posedge ref_clk_i);
    req_o <= 1'b1;
    wr_o <= w;
    addr_o <= a;
  endtask
  // released address is scrambled so a stale value is never trusted
  task automatic quiet();
    @(posedge ref_clk_i);
    req_o <= 1'b0;
    addr_o <= ~addr_o;
  endtask
endmodule
`default_nettype wire

// [verification/dspb_bank_tb.sv]
// self-checking bench for the parameter bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %0t %h %h", $time, g, e); end end
module dspb_bank_tb;
  logic        ref_clk_i, rst_i, req_i, wr_i, ack_o, err_o, warn_i, chan_excl_i;
  logic [3:0]  err_class_i;
  logic [7:0]  chan_id_i;
  logic [15:0] addr_i, opmode_i, action_word_o, acc_q;
  logic [31:0] ref_speed_i, act_speed_i, rdata_o, ref_acc_o, ramp;
  logic [32:0] e, exp_q[$];
  int          fail_count, comparisons, cyc;
  dspb_master i_mst (.ref_clk_i(ref_clk_i), .req_o(req_i), .wr_o(wr_i), .addr_o(addr_i));
  dspb_bank #(.SAMPLE_CYC(32'h8)) i_dut (.*);
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (ramp != 32'h0) ref_speed_i <= ref_speed_i + ramp;
    if (cyc == 3000) begin
      fail_count++;
      wrap_up();
    end
  end
  always @(posedge ref_clk_i) begin
    if (ack_o === 1'b1) begin
      e = exp_q.pop_front();
      `CHK({err_o, rdata_o}, e)
    end
  end
  function automatic logic [15:0] aw();
    logic signed [31:0] a = act_speed_i;
    logic signed [31:0] s = ref_speed_i;
    aw = {1'b0, s != 0 && ramp == 0, ramp != 0 && s[31] == ramp[31],
      ramp != 0 && s[31] != ramp[31], s == 0, 2'h0, a <= -9, a >= 9,
      a < 9 && a > -9, 1'h0, err_class_i, warn_i};
  endfunction
  task automatic xf(input logic [15:0] a, input logic w, input logic [32:0] x);
    exp_q.push_back(x);
    i_mst.put(a, w);
  endtask
  task automatic sweep();
    if (chan_id_i inside {[8'h1:8'h7], 8'h9}) acc_q = {chan_id_i, 7'h0, chan_excl_i};
    `CHK(ref_acc_o, ramp * 32'h1F40)
    `CHK(action_word_o, aw())
    xf(16'h1C08, 1'b0, {17'h0, aw()});
    xf(16'h0118, 1'b0, {17'h0, acc_q});
    xf(16'h1B08, 1'b0, {1'b0, 32'($signed(opmode_i))});
    xf(16'h1F12, 1'b0, {1'b0, ramp * 32'h1F40});
    xf(16'h1F12, 1'b1, 33'h100000000);
    xf(16'h0119, 1'b0, 33'h100000000);
    i_mst.quiet();
  endtask
  task automatic wrap_up();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    {warn_i, chan_excl_i, err_class_i, chan_id_i, opmode_i, acc_q} = '0;
    {ref_speed_i, act_speed_i, ramp, fail_count, comparisons, cyc} = '0;
    void'($urandom(79421));
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    sweep();
    repeat (12) begin
      @(posedge ref_clk_i);
      ramp <= '0;
      @(posedge ref_clk_i);
      {warn_i, chan_excl_i, err_class_i} <= 6'($urandom);
      chan_id_i <= 8'($urandom_range(10, 0));
      opmode_i <= 16'($urandom_range(12, 0) - 6);
      act_speed_i <= $urandom_range(20, 0) - 10;
      ref_speed_i <= 32'($urandom_range(2, 0)) * 32'h5DC - 32'h5DC;
      @(posedge ref_clk_i);
      ramp <= (ref_speed_i == 0) ? '0 : $urandom_range(6, 0) - 3;
      repeat (30) @(posedge ref_clk_i);
      sweep();
    end
    repeat (3) @(posedge ref_clk_i);
    if (exp_q.size() != 0) fail_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
